/* shared/bdt_pkg.sv */
package bdt_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INT_STAT = 4'h1;
  localparam logic [3:0] ADDR_INT_MASK = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] ADDR_CNT_LO = 4'h4;
  localparam logic [3:0] ADDR_CNT_HI = 4'h5;

  // control register fields
  localparam int unsigned CTRL_STOP = 0;
  localparam int unsigned CTRL_TEST = 1;
  localparam int unsigned CTRL_EXP = 2;

  // interrupt status and mask fields
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_EXPIRED = 0;
  localparam int unsigned INT_START = 1;

  // reset values
  localparam logic [1:0] INT_MASK_RST = 2'h0;
  localparam logic [1:0] INT_STAT_RST = 2'h0;

  // timebase and timing figures
  localparam longint RTC_HZ = 32768;
  localparam longint TIMEOUT_US = 62500;
  localparam longint BLINK_ON_MS = 125;
  localparam longint BLINK_PERIOD_MS = 1000;
  localparam longint TIMEOUT_TICKS = TIMEOUT_US * RTC_HZ / 1000000;
  localparam longint BLINK_ON_TICKS = BLINK_ON_MS * RTC_HZ / 1000;
  localparam longint BLINK_PERIOD_TICKS = BLINK_PERIOD_MS * RTC_HZ / 1000;

  // counter widths
  localparam int unsigned CNT_W = 11;
  localparam int unsigned BLINK_W = 15;

  // count of pins passed through the synchroniser
  localparam int unsigned SYNC_W = 3;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_COUNT = 2'b01,
    ST_OVFL = 2'b10,
    ST_DISABLED = 2'b11
  } bdt_state_t;

endpackage

/* hw/bdt_sync.sv */
`timescale 1ns/1ps
module bdt_sync
  import bdt_pkg::*;
#(
  parameter int unsigned W = SYNC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bdt_sync_t;

  bdt_sync_t q;
  bdt_sync_t d;

  // first stage feeds only the second stage
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule

/* hw/bdt_blink.sv */
`timescale 1ns/1ps
module bdt_blink
  import bdt_pkg::*;
#(
  parameter int unsigned DIV_W = BLINK_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic blink_en,
  output logic led_n
);

  localparam logic [DIV_W-1:0] ON_TICKS = DIV_W'(BLINK_ON_TICKS);

  generate
    if ((64'(1) << DIV_W) != BLINK_PERIOD_TICKS) begin : g_bad_div
      $error("blink divider width does not match the blink period");
    end
  endgenerate

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic led_n;
  } bdt_blink_t;

  localparam bdt_blink_t BLINK_RST = '{div: '0, led_n: 1'b1};

  bdt_blink_t q;
  bdt_blink_t d;

  always_comb begin
    d = q;
    // free-running divider, wraps once per blink period
    if (tick) begin
      d.div = q.div + DIV_W'(1);
    end
    // lit for the first slice of each period, active low
    d.led_n = ~(blink_en && (q.div < ON_TICKS));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= BLINK_RST;
    end else begin
      q <= d;
    end
  end

  assign led_n = q.led_n;

endmodule

/* hw/bdt_timer.sv */
`timescale 1ns/1ps
module bdt_timer
  import bdt_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rtc_tick,
  input wire logic main_power_on_reset,
  input wire logic program_strap_pin,
  input wire logic ctrl_reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  output logic irq,
  output logic fault_led_n
);

  generate
    if ((64'(1) << CW) != TIMEOUT_TICKS) begin : g_bad_cnt
      $error("counter width does not give the documented timeout");
    end
    if (CW > 16 || CW < 9) begin : g_bad_range
      $error("counter width outside the readable range");
    end
  endgenerate

  typedef struct packed {
    logic tick_prev;
    logic timeout_stop_bit;
    logic timeout_selftest_bit;
    logic timeout_expired_flag;
    logic carry;
    logic [CW-1:0] cnt;
    bdt_state_t st;
    logic blink;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic [DATA_W-1:0] rd_data;
  } bdt_regs_t;

  localparam bdt_regs_t REGS_RST = '{
    tick_prev: 1'b0,
    timeout_stop_bit: 1'b0,
    timeout_selftest_bit: 1'b0,
    timeout_expired_flag: 1'b0,
    carry: 1'b0,
    cnt: '0,
    st: ST_INIT,
    blink: 1'b0,
    int_stat: INT_STAT_RST,
    int_mask: INT_MASK_RST,
    irq: 1'b0,
    rd_data: '0
  };

  bdt_regs_t q;
  bdt_regs_t d;

  logic [SYNC_W-1:0] pins_s;
  logic rtc_s;
  logic por_s;
  logic strap_s;
  logic tick;
  logic init;
  logic counting;
  logic [CW:0] cnt_sum;
  logic carry_evt;
  logic start_evt;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [INT_W-1:0] evts;
  logic led_n_w;

  // pins from other domains pass two flops first
  bdt_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({program_strap_pin, main_power_on_reset, rtc_tick}),
    .sync_out(pins_s)
  );

  assign rtc_s = pins_s[0];
  assign por_s = pins_s[1];
  assign strap_s = pins_s[2];

  // rising edge of the rtc timebase, slow start tolerated
  assign tick = rtc_s & ~q.tick_prev;

  // controller reset, strap or self-test hold the counter in init
  assign init = ctrl_reset | strap_s | q.timeout_selftest_bit;

  // count only when stop, init and carry are all low
  assign counting = ~q.timeout_stop_bit & ~init & ~q.carry;

  // one wider than the counter, top bit is the carry out
  assign cnt_sum = {1'b0, q.cnt} + {{CW{1'b0}}, 1'b1};

  assign carry_evt = counting & tick & cnt_sum[CW];

  assign wr_ctrl = wr_en && (addr == ADDR_CTRL);
  assign wr_stat = wr_en && (addr == ADDR_INT_STAT);
  assign wr_mask = wr_en && (addr == ADDR_INT_MASK);

  always_comb begin
    d = q;
    start_evt = 1'b0;
    evts = '0;

    d.tick_prev = rtc_s;

    // control bits
    if (wr_ctrl) begin
      d.timeout_stop_bit = wr_data[CTRL_STOP];
      d.timeout_selftest_bit = wr_data[CTRL_TEST];
      if (wr_data[CTRL_EXP]) begin
        d.timeout_expired_flag = 1'b0;
      end
    end

    // operating state, stop bit takes priority over all but main power-on reset
    if (q.timeout_stop_bit) begin
      d.st = ST_DISABLED;
    end else if (init) begin
      d.st = ST_INIT;
    end else if (q.carry) begin
      d.st = ST_OVFL;
    end else begin
      d.st = ST_COUNT;
    end

    // counter clear and advance
    if (init) begin
      d.cnt = '0;
      d.carry = 1'b0;
    end else if (counting && tick) begin
      d.cnt = cnt_sum[CW-1:0];
      if (cnt_sum[CW]) begin
        d.carry = 1'b1;
      end
    end

    // expiry flag, a new carry wins over a clearing write
    if (carry_evt) begin
      d.timeout_expired_flag = 1'b1;
    end

    // blinking latches on carry, only reset, strap or test ends it
    if (ctrl_reset || strap_s || q.timeout_selftest_bit) begin
      d.blink = 1'b0;
    end else if (carry_evt) begin
      d.blink = 1'b1;
    end

    // counting just began after init
    start_evt = (d.st == ST_COUNT) && (q.st == ST_INIT);

    evts[INT_EXPIRED] = carry_evt;
    evts[INT_START] = start_evt;

    // sticky status, write one clears, set wins
    if (wr_stat) begin
      d.int_stat = q.int_stat & ~wr_data[INT_W-1:0];
    end
    d.int_stat = d.int_stat | evts;

    if (wr_mask) begin
      d.int_mask = wr_data[INT_W-1:0];
    end

    d.irq = |(d.int_stat & d.int_mask);

    // read data valid only in the cycle after the strobe
    d.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        ADDR_CTRL: begin
          d.rd_data[CTRL_STOP] = q.timeout_stop_bit;
          d.rd_data[CTRL_TEST] = q.timeout_selftest_bit;
          d.rd_data[CTRL_EXP] = q.timeout_expired_flag;
        end
        ADDR_INT_STAT: begin
          d.rd_data[INT_W-1:0] = q.int_stat;
        end
        ADDR_INT_MASK: begin
          d.rd_data[INT_W-1:0] = q.int_mask;
        end
        ADDR_STATE: begin
          d.rd_data[1:0] = q.st;
          d.rd_data[2] = q.carry;
          d.rd_data[3] = q.blink;
        end
        ADDR_CNT_LO: begin
          d.rd_data = q.cnt[7:0];
        end
        ADDR_CNT_HI: begin
          d.rd_data[CW-9:0] = q.cnt[CW-1:8];
        end
        default: begin
          d.rd_data = '0;
        end
      endcase
    end

    // main power-on reset clears every register here but tick_prev, not the led divider
    if (por_s) begin
      d = REGS_RST;
      d.tick_prev = rtc_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // led divider runs on every tick, even after the counter stops
  bdt_blink #(
    .DIV_W(BLINK_W)
  ) u_blink (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .blink_en(q.blink),
    .led_n(led_n_w)
  );

  assign rd_data = q.rd_data;
  assign irq = q.irq;
  assign fault_led_n = led_n_w;

endmodule

/* tb/bdt_rtc_src.sv */
`timescale 1ns/1ps
module bdt_rtc_src (
  input wire logic clk,
  input wire logic run,
  output logic rtc_tick,
  output int ticks
);
  int ph = 0;
  logic level = 1'b0;
  int rises = 0;
  // timebase, 6 clocks per half, still until run
  always @(posedge clk) begin
    if (run) begin
      ph <= (ph == 5) ? 0 : ph + 1;
      if (ph == 5) begin
        level <= ~level;
        if (!level) rises <= rises + 1;
      end
    end
  end
  assign rtc_tick = level;
  assign ticks = rises;
endmodule

/* tb/bdt_timer_assertions.sv */
`timescale 1ns/1ps
module bdt_timer_assertions
  import bdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rtc_tick,
  input wire logic main_power_on_reset,
  input wire logic program_strap_pin,
  input wire logic ctrl_reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic irq,
  input wire logic fault_led_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rst_held;
    ctrl_reset [*3];
  endsequence
  sequence s_rd_lo;
    rd_en && addr == ADDR_CNT_LO;
  endsequence
  a_rd_idle: assert property (
    !$past(rd_en) |-> rd_data == 8'h00) else $error("rd_data not idle");
  a_unmapped_rd: assert property (
    rd_en && addr > ADDR_CNT_HI |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_cnt_hi_w: assert property (
    rd_en && addr == ADDR_CNT_HI |=> rd_data[7:3] == 5'h00)
    else $error("counter wider than 11 bits");
  a_cnt_clear: assert property (
    s_rst_held ##0 s_rd_lo |=> rd_data == 8'h00)
    else $error("counter not cleared in reset");
  a_rst_dark: assert property (
    ctrl_reset ##1 ctrl_reset |=> fault_led_n) else $error("led lit in reset");
  a_strap_dark: assert property (
    program_strap_pin [*6] |=> fault_led_n) else $error("led lit on strap");
  a_por_quiet: assert property (
    main_power_on_reset [*6] |=> !irq && fault_led_n)
    else $error("not quiet in power reset");
  a_test_dark: assert property (
    wr_en && addr == ADDR_CTRL && wr_data[CTRL_TEST] |-> ##[1:3] fault_led_n)
    else $error("led lit in self-test");
  a_mask_quiet: assert property (
    wr_en && addr == ADDR_INT_MASK && wr_data[1:0] == 2'h0 |-> ##[1:2] !irq)
    else $error("irq high while masked");
endmodule

/* tb/boot_deadman_timer_bench.sv */
`timescale 1ns/1ps
module boot_deadman_timer_bench
  import bdt_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic rtc_tick;
  logic main_power_on_reset = 1'b0;
  logic program_strap_pin = 1'b0;
  logic ctrl_reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic irq;
  logic fault_led_n;
  int ticks;
  int err_total = 0;
  int tests_run = 0;
  int seed = 35236;
  int t0;
  int n;
  always #2.5 clk = ~clk;
  bdt_timer dut (.clk(clk), .rst_n(rst_n), .rtc_tick(rtc_tick),
    .main_power_on_reset(main_power_on_reset),
    .program_strap_pin(program_strap_pin), .ctrl_reset(ctrl_reset),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .fault_led_n(fault_led_n));
  bdt_rtc_src src (.clk(clk), .run(run), .rtc_tick(rtc_tick), .ticks(ticks));
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 cmp(rd_data & m, e);
  endtask
  // reach tick count k, then settle in the low half
  task automatic sync_to(int k);
    while (ticks < k) @(posedge clk);
    @(negedge rtc_tick);
    #1;
  endtask
  function automatic logic exp_led(int t);
    return (t % 32768) >= 4096;
  endfunction
  // about 50k cycles of test, limit at 80k cycles
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_CNT_LO, 8'hff, 8'h00);
    rd(ADDR_STATE, 8'h03, 8'h00);
    rd(4'hf, 8'hff, 8'h00);
    rd(ADDR_INT_MASK, 8'hff, 8'h00);
    wr(ADDR_INT_MASK, 8'h03);
    sync_to(1);
    ctrl_reset <= 1'b0;
    t0 = ticks;
    n = 20 + ($random(seed) & 63);
    sync_to(t0 + n);
    rd(ADDR_CNT_LO, 8'hff, n[7:0]);
    rd(ADDR_CNT_HI, 8'hff, 8'h00);
    rd(ADDR_STATE, 8'h0f, 8'h01);
    rd(ADDR_INT_STAT, 8'hff, 8'h02);
    cmp({7'h00, irq}, 8'h01);
    wr(ADDR_INT_STAT, 8'h02);
    @(posedge clk);
    #1 cmp({7'h00, irq}, 8'h00);
    sync_to(ticks + 1);
    wr(ADDR_CTRL, 8'h01);
    n = ticks - t0;
    sync_to(ticks + 20);
    rd(ADDR_CNT_LO, 8'hff, n[7:0]);
    rd(ADDR_STATE, 8'h03, 8'h03);
    wr(ADDR_CTRL, 8'h00);
    t0 = ticks - n;
    sync_to(t0 + 2047);
    cmp({7'h00, irq}, 8'h00);
    rd(ADDR_CTRL, 8'h04, 8'h00);
    sync_to(t0 + 2048);
    cmp({7'h00, irq}, 8'h01);
    rd(ADDR_STATE, 8'h0f, 8'h0e);
    rd(ADDR_CTRL, 8'hff, 8'h04);
    cmp({7'h00, fault_led_n}, {7'h00, exp_led(ticks)});
    sync_to(ticks + 10);
    rd(ADDR_STATE, 8'h0f, 8'h0e);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h04, 8'h04);
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CTRL, 8'h04, 8'h00);
    rd(ADDR_INT_STAT, 8'hff, 8'h01);
    wr(ADDR_INT_MASK, 8'h00);
    @(posedge clk);
    #1 cmp({7'h00, irq}, 8'h00);
    wr(ADDR_INT_STAT, 8'h03);
    sync_to(4095);
    cmp({7'h00, fault_led_n}, {7'h00, exp_led(ticks)});
    sync_to(4097);
    cmp({7'h00, fault_led_n}, {7'h00, exp_led(ticks)});
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_STATE, 8'h0f, 8'h00);
    rd(ADDR_CNT_LO, 8'hff, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_STATE, 8'h03, 8'h01);
    program_strap_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd(ADDR_STATE, 8'h03, 8'h00);
    program_strap_pin <= 1'b0;
    wr(ADDR_CTRL, 8'h01);
    main_power_on_reset <= 1'b1;
    repeat (8) @(posedge clk);
    main_power_on_reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_CTRL, 8'hff, 8'h00);
    stop_test();
  end
endmodule
bind bdt_timer bdt_timer_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .rtc_tick(rtc_tick), .main_power_on_reset(main_power_on_reset),
  .program_strap_pin(program_strap_pin), .ctrl_reset(ctrl_reset),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .irq(irq), .fault_led_n(fault_led_n));
